/* logic/windowed_watchdog_map.svh */
// constants of the windowed watchdog and wake-up timer
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH

// watchdog down-counter width
`define WDOG_CNT_W          16
// system clock rate in MHz (period 40 ns)
`define WDOG_SYS_MHZ        25
// least length of the reset pulse sent to processor and front end
`define WDOG_RST_PULSE_NS   10000
// pulse length in system cycles, rounded up
`define WDOG_RST_PULSE_CYC  ((`WDOG_RST_PULSE_NS * `WDOG_SYS_MHZ + 999) / 1000)
// reset pulse counter width
`define WDOG_RST_CNT_W      9
// wake-up period select width and largest legal code (8 s)
`define WAKE_SEL_W          3
`define WAKE_SEL_MAX        3'h6
// slow ticks in the shortest wake-up period (125 ms at 32768 Hz)
`define WAKE_BASE_TICKS     4096
// wake-up counter width, fits 8 s of slow ticks
`define WAKE_CNT_W          19
// reset values
`define WDOG_FLAG_RST       1'b0
`define WDOG_CNT_RST        16'h0000

`endif

/* logic/windowed_watchdog_pkg.sv */
// types shared by the windowed watchdog files
`default_nettype none
`include "windowed_watchdog_map.svh"
package wdog_pkg;
  // watchdog down-counter value
  typedef logic [`WDOG_CNT_W-1:0] wd_count_t;
  // wake-up period code: 0=125ms .. 6=8s
  typedef logic [`WAKE_SEL_W-1:0] wake_sel_t;
  // wake-up tick counter
  typedef logic [`WAKE_CNT_W-1:0] wake_count_t;
  // watchdog sequencing
  typedef enum logic [1:0] {WD_IDLE, WD_COUNT, WD_RESET} wd_state_e;
endpackage
`default_nettype wire

/* logic/wake_if.sv */
// carrier between the watchdog core and its wake-up timer
`default_nettype none
interface wake_if;
  import wdog_pkg::*;
  logic      ce;         // clock enable
  logic      slow_tick;  // one-cycle slow oscillator tick
  logic      low_power;  // hibernate or sleep active
  wake_sel_t period_sel; // wake-up period code
  logic      wake;       // one-cycle wake-up event
  modport ctrl  (output ce, slow_tick, low_power, period_sel, input wake);
  modport timer (input ce, slow_tick, low_power, period_sel, output wake);
endinterface
`default_nettype wire

/* logic/wake_timer.sv */
// periodic wake-up timer running on slow oscillator ticks
`default_nettype none
`include "windowed_watchdog_map.svh"
module wake_timer
  import wdog_pkg::*;
#(
  parameter int BASE_TICKS = `WAKE_BASE_TICKS
) (
  input  wire logic clk,
  input  wire logic rst_b,
  wake_if.timer     wif
);
  wake_count_t cnt_r;     // slow ticks since last wake
  wake_count_t cnt_nxt;   // next tick count
  wake_sel_t   sel_eff;   // period code clamped to 8 s
  wake_count_t period;    // period length in slow ticks
  logic        expire;    // period elapses on this tick
  logic        wake_r;    // registered wake event

  // codes above 8 s fall back to 8 s
  assign sel_eff = (wif.period_sel > `WAKE_SEL_MAX) ? `WAKE_SEL_MAX : wif.period_sel;
  // 125 ms doubled per step up to 8 s
  assign period  = wake_count_t'(BASE_TICKS) << sel_eff;
  assign expire  = wif.low_power && wif.slow_tick && (cnt_r == period - 1'b1);
  // count only in low power, restart on expiry
  assign cnt_nxt = !wif.low_power ? '0 :
                   expire         ? '0 :
                   wif.slow_tick  ? cnt_r + 1'b1 : cnt_r;
  assign wif.wake = wake_r;

  // tick counter and wake pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r  <= '0;
      wake_r <= 1'b0;
    end else if (wif.ce) begin
      cnt_r  <= cnt_nxt;
      wake_r <= expire;
    end
  end

  // wake only while hibernating or sleeping
  AST_WAKE_LOW_POWER: assert property (@(posedge clk) disable iff (!rst_b)
    wif.ce && expire |=> wake_r && $past(wif.low_power))
    else $error("wake event lost or raised outside low power");
  AST_WAKE_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
    wif.ce && wif.low_power && wif.slow_tick && cnt_r == period - 1'b1 |=> cnt_r == '0)
    else $error("wake counter did not restart at period end");
  COV_WAKE: cover property (@(posedge clk) disable iff (!rst_b) wake_r);
endmodule
`default_nettype wire

/* logic/windowed_watchdog.sv */
// windowed watchdog of the battery front end with wake-up timer
`default_nettype none
`include "windowed_watchdog_map.svh"
// Behaviour
// - missed service resets processor and front end
// - wake periods 125ms to 8s selectable
// - wake event each period in low power
// - counter steps on slow oscillator only
// - watchdog reset sets its own status flag
// - flag kept across watchdog reset, cleared otherwise
// - reset hits processor and front end both
// - service above window value forces reset
// - counter reaching zero forces reset
module windowed_watchdog
  import wdog_pkg::*;
#(
  parameter int WAKE_BASE_TICKS = `WAKE_BASE_TICKS
) (
  input  wire logic      SYS_CLK,
  input  wire logic      RST_B,
  input  wire logic      CLK_EN,
  input  wire logic      SLOW_OSC,
  input  wire logic      WDT_ENABLE,
  input  wire wd_count_t WDT_START,
  input  wire wd_count_t WDT_WINDOW,
  input  wire logic      WDT_SERVICE,
  input  wire logic      WDT_FLAG_CLEAR,
  input  wire logic      LOW_POWER,
  input  wire wake_sel_t WAKE_SEL,
  output logic           WAKE_EVENT,
  output logic           MCU_RESET_B,
  output logic           FE_RESET_B,
  output logic           WDT_RESET_FLAG,
  output logic           WDT_EARLY_FLAG,
  output wd_count_t      WDT_COUNT,
  output logic           WDT_RUNNING
);
  wd_state_e                 state_r;     // watchdog sequencer
  wd_state_e                 state_nxt;   // next sequencer state
  wd_count_t                 cnt_r;       // watchdog down-counter
  wd_count_t                 cnt_nxt;     // next counter value
  logic [`WDOG_RST_CNT_W-1:0] pulse_r;    // reset pulse cycles left
  logic [`WDOG_RST_CNT_W-1:0] pulse_nxt;  // next pulse count
  logic                      osc_d_r;     // slow oscillator last level
  logic                      slow_tick;   // rising edge of slow oscillator
  logic                      early;       // service before window opens
  logic                      in_window;   // service inside open window
  logic                      expired;     // counter has reached zero
  logic                      fire;        // watchdog issues reset now
  logic                      flag_r;      // watchdog caused last reset
  logic                      early_r;     // last reset was an early service
  logic                      rst_out_r;   // reset pulse active

  wake_if wif ();

  // slow oscillator edge is the only counting time base
  assign slow_tick = SLOW_OSC && !osc_d_r;

  // service strobe arrives only from the bridge port
  assign early     = (state_r == WD_COUNT) && WDT_SERVICE && (cnt_r > WDT_WINDOW);
  assign in_window = (state_r == WD_COUNT) && WDT_SERVICE && !early && (cnt_r != '0);
  assign expired   = (state_r == WD_COUNT) && (cnt_r == '0);
  assign fire      = early || expired;

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      WD_IDLE: begin
        if (WDT_ENABLE) begin
          state_nxt = WD_COUNT;
        end
      end
      WD_COUNT: begin
        if (fire) begin
          state_nxt = WD_RESET;
        end else if (!WDT_ENABLE) begin
          state_nxt = WD_IDLE;
        end
      end
      WD_RESET: begin
        if (pulse_r == '0) begin
          state_nxt = WD_IDLE;
        end
      end
    endcase
  end

  // counter next value
  always_comb begin
    cnt_nxt = cnt_r;
    if (state_r != WD_COUNT) begin
      // held at start while stopped or resetting
      cnt_nxt = WDT_START;
    end else if (in_window) begin
      cnt_nxt = WDT_START;
    end else if (slow_tick && !fire) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // reset pulse length counter
  assign pulse_nxt = fire             ? `WDOG_RST_CNT_W'(`WDOG_RST_PULSE_CYC - 1) :
                     (pulse_r != '0)  ? pulse_r - 1'b1 : pulse_r;

  // sequencer, counter and pulse registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state_r <= WD_IDLE;
      cnt_r   <= `WDOG_CNT_RST;
      pulse_r <= '0;
      osc_d_r <= 1'b0;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pulse_r <= pulse_nxt;
      osc_d_r <= SLOW_OSC;
    end
  end

  // reset output register, high for the whole pulse
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      rst_out_r <= 1'b0;
    end else if (CLK_EN) begin
      rst_out_r <= (state_nxt == WD_RESET);
    end
  end

  // status flags: the pin reset or WDT_FLAG_CLEAR clears them, a watchdog reset sets flag_r and loads early_r with its cause
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      flag_r  <= `WDOG_FLAG_RST;
      early_r <= 1'b0;
    end else if (CLK_EN) begin
      if (fire) begin
        // set wins over a same-cycle clear
        flag_r  <= 1'b1;
        early_r <= early;
      end else if (WDT_FLAG_CLEAR) begin
        flag_r  <= 1'b0;
        early_r <= 1'b0;
      end
    end
  end

  // wake-up timer hookup
  assign wif.ce         = CLK_EN;
  assign wif.slow_tick  = slow_tick;
  assign wif.low_power  = LOW_POWER;
  assign wif.period_sel = WAKE_SEL;

  wake_timer #(
    .BASE_TICKS (WAKE_BASE_TICKS)
  ) u_wake (
    .clk   (SYS_CLK),
    .rst_b (RST_B),
    .wif   (wif.timer)
  );

  // outputs
  assign WAKE_EVENT     = wif.wake;
  assign MCU_RESET_B    = !rst_out_r;
  assign FE_RESET_B     = !rst_out_r;
  assign WDT_RESET_FLAG = flag_r;
  assign WDT_EARLY_FLAG = early_r;
  assign WDT_COUNT      = cnt_r;
  assign WDT_RUNNING    = (state_r == WD_COUNT);

  // checks: reset sources
  AST_TIMEOUT_RESET: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    CLK_EN && state_r == WD_COUNT && cnt_r == '0 |=> state_r == WD_RESET && !MCU_RESET_B)
    else $error("zero count did not reset");
  AST_EARLY_RESET: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    CLK_EN && state_r == WD_COUNT && WDT_SERVICE && cnt_r > WDT_WINDOW |=> !MCU_RESET_B && WDT_EARLY_FLAG)
    else $error("early service did not reset");
  // checks: counter behaviour
  AST_RELOAD: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    CLK_EN && state_r == WD_COUNT && WDT_SERVICE && cnt_r <= WDT_WINDOW && cnt_r != '0
    |=> cnt_r == $past(WDT_START) && MCU_RESET_B)
    else $error("window service did not reload");
  AST_DECREMENT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    CLK_EN && state_r == WD_COUNT && slow_tick && !WDT_SERVICE && cnt_r != '0 && WDT_ENABLE
    |=> cnt_r == $past(cnt_r) - 1'b1)
    else $error("counter missed a slow tick");
  AST_SLOW_ONLY: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state_r == WD_COUNT && !slow_tick && !WDT_SERVICE && WDT_ENABLE && cnt_r != '0
    |=> $stable(cnt_r))
    else $error("counter moved without slow tick");
  // a frozen clock enable holds the counter, state, pulse count and reset flag
  AST_FREEZE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !CLK_EN |=> $stable(cnt_r) && $stable(state_r) && $stable(pulse_r) && $stable(flag_r))
    else $error("state moved while clock enable low");
  // checks: flags and reset outputs
  AST_FLAG_SET: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    $fell(MCU_RESET_B) |-> WDT_RESET_FLAG)
    else $error("watchdog reset without flag");
  AST_FLAG_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    WDT_RESET_FLAG && !WDT_FLAG_CLEAR |=> WDT_RESET_FLAG)
    else $error("flag lost without clear");
  AST_SET_WINS: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    CLK_EN && fire && WDT_FLAG_CLEAR |=> WDT_RESET_FLAG)
    else $error("flag clear beat a same-cycle watchdog reset");
  AST_BOTH_RESETS: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    MCU_RESET_B == FE_RESET_B)
    else $error("processor and front end reset differ");
  AST_PULSE_LEN: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    CLK_EN && fire |=> (!MCU_RESET_B)[*8])
    else $error("reset pulse too short");
  // pulse ends once its counter runs out
  AST_PULSE_DONE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    CLK_EN && state_r == WD_RESET && pulse_r == '0 |=> MCU_RESET_B)
    else $error("reset pulse did not end");
  // main scenarios reached
  COV_TIMEOUT: cover property (@(posedge SYS_CLK) disable iff (!RST_B) expired && CLK_EN);
  COV_EARLY:   cover property (@(posedge SYS_CLK) disable iff (!RST_B) early && CLK_EN);
  COV_RELOAD:  cover property (@(posedge SYS_CLK) disable iff (!RST_B) in_window && CLK_EN);
  COV_ENABLE_DROP: cover property (@(posedge SYS_CLK) disable iff (!RST_B) CLK_EN && state_r == WD_COUNT && !WDT_ENABLE);
endmodule
`default_nettype wire

/* test/fw_model.sv */
// firmware-side model that services the watchdog over the bridge
`default_nettype none
module fw_model (
  input  wire logic clk,
  output var logic  service
);
  timeunit 1ns;
  timeprecision 1ns;
  // bridge strobe idle until firmware kicks
  initial service = 1'b0;
  // one-cycle service strobe, launched off the falling edge
  task automatic kick();
    @(negedge clk) service = 1'b1;
    @(negedge clk) service = 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// self-checking bench of the windowed watchdog and wake timer
`default_nettype none
`include "windowed_watchdog_map.svh"
module testbench
  import wdog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // row: slow ticks before service, early reset expected
  typedef struct {int tk; logic early;} row_s;
  logic      sys_clk, rst_b, clk_en, slow_osc, wdt_enable, wdt_service, flag_clr, low_power;
  logic      wake_event, mcu_rst_b, fe_rst_b, rst_flag, early_flag, running;
  wd_count_t wdt_start, wdt_window, wdt_count;
  wake_sel_t wake_sel;
  int        fail_count, tests_run, n, ev;
  row_s      rows [4] = '{'{5, 1'b0}, '{4, 1'b0}, '{3, 1'b1}, '{0, 1'b1}};

  // small wake base keeps periods short
  windowed_watchdog #(.WAKE_BASE_TICKS(4)) dut_u (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .CLK_EN(clk_en), .SLOW_OSC(slow_osc),
    .WDT_ENABLE(wdt_enable), .WDT_START(wdt_start), .WDT_WINDOW(wdt_window),
    .WDT_SERVICE(wdt_service), .WDT_FLAG_CLEAR(flag_clr), .LOW_POWER(low_power),
    .WAKE_SEL(wake_sel), .WAKE_EVENT(wake_event), .MCU_RESET_B(mcu_rst_b),
    .FE_RESET_B(fe_rst_b), .WDT_RESET_FLAG(rst_flag), .WDT_EARLY_FLAG(early_flag),
    .WDT_COUNT(wdt_count), .WDT_RUNNING(running));
  fw_model fw_u (.clk(sys_clk), .service(wdt_service));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // shared mismatch report
  task automatic note(input logic ok, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (!ok) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input wd_count_t g, input wd_count_t e);
    note(g === e, 32'(g), 32'(e));
  endtask
  task automatic chk_bit(input logic g, input logic e);
    note(g === e, 32'(g), 32'(e));
  endtask
  task automatic chk_num(input int g, input int e);
    note(g == e, g, e);
  endtask

  // one slow oscillator period, counting wake pulses
  task automatic tick();
    for (int k = 0; k < 6; k++) begin
      slow_osc = (k < 2);
      @(negedge sys_clk);
      if (wake_event === 1'b1) ev++;
    end
  endtask

  // reset for 5 cycles, then wait for the start load
  task automatic restart();
    rst_b = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk_bit(rst_flag, 1'b0);
    chk_bit(mcu_rst_b, 1'b1);
    rst_b = 1'b1;
    n = 0;
    while (wdt_count !== wdt_start && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // counts, then verdict
  task automatic give_verdict();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #2000000;
    fail_count++;
    give_verdict();
  end

  // main sequence
  initial begin
    fail_count = 0;
    tests_run = 0;
    ev = 0;
    rst_b = 1'b0;
    slow_osc = 1'b0;
    flag_clr = 1'b0;
    low_power = 1'b0;
    wake_sel = '0;
    clk_en = 1'b1;
    wdt_enable = 1'b1;
    wdt_start = 16'h0008;
    wdt_window = 16'h0004;
    // table: service at count 3, 4 (window edge), 5, 8
    for (int i = 0; i < 4; i++) begin
      restart();
      chk_cnt(wdt_count, wdt_start);
      repeat (rows[i].tk) tick();
      chk_cnt(wdt_count, wdt_start - wd_count_t'(rows[i].tk));
      fw_u.kick();
      @(negedge sys_clk);
      chk_bit(mcu_rst_b, !rows[i].early);
      chk_bit(fe_rst_b, !rows[i].early);
      chk_bit(early_flag, rows[i].early);
      chk_bit(rst_flag, rows[i].early);
      if (!rows[i].early) chk_cnt(wdt_count, wdt_start);
      $display("row %0d done", i);
    end
    // reset pulse length, flag kept after it
    n = 0;
    while (mcu_rst_b !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    // first pulse cycle already passed before the loop
    chk_num(n + 1, `WDOG_RST_PULSE_CYC);
    chk_bit(rst_flag, 1'b1);
    // no slow ticks, no movement
    repeat (25) @(negedge sys_clk);
    chk_cnt(wdt_count, wdt_start);
    chk_bit(running, 1'b1);
    $display("pulse test done");
    // frozen clock enable ignores slow ticks, then counting resumes
    clk_en = 1'b0;
    repeat (3) tick();
    chk_cnt(wdt_count, wdt_start);
    clk_en = 1'b1;
    tick();
    chk_cnt(wdt_count, wdt_start - 16'h0001);
    // dropping the enable returns to idle with the start value
    wdt_enable = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_bit(running, 1'b0);
    chk_cnt(wdt_count, wdt_start);
    wdt_enable = 1'b1;
    $display("enable test done");
    // missed service runs out to zero
    restart();
    repeat (8) tick();
    n = 0;
    while (mcu_rst_b !== 1'b0 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit(mcu_rst_b, 1'b0);
    chk_bit(rst_flag, 1'b1);
    chk_bit(early_flag, 1'b0);
    chk_bit(running, 1'b0);
    flag_clr = 1'b1;
    @(negedge sys_clk);
    flag_clr = 1'b0;
    @(negedge sys_clk);
    chk_bit(rst_flag, 1'b0);
    $display("timeout test done");
    // early service with a same-cycle clear: the set wins
    restart();
    flag_clr = 1'b1;
    fw_u.kick();
    flag_clr = 1'b0;
    @(negedge sys_clk);
    chk_bit(rst_flag, 1'b1);
    chk_bit(early_flag, 1'b1);
    $display("set wins test done");
    // wake timer over every period code
    wdt_enable = 1'b0;
    restart();
    // code 7 acts as the 8 s code
    for (int s = 0; s < 8; s++) begin
      low_power = 1'b0;
      wake_sel = wake_sel_t'(s);
      @(negedge sys_clk);
      low_power = 1'b1;
      ev = 0;
      repeat ((4 << ((s > 6) ? 6 : s)) - 1) tick();
      chk_num(ev, 0);
      tick();
      chk_num(ev, 1);
    end
    // awake: no events
    low_power = 1'b0;
    ev = 0;
    repeat (8) tick();
    chk_num(ev, 0);
    $display("wake test done");
    give_verdict();
  end
endmodule
`default_nettype wire
